// [bench/line_pass_sleep_chk.sv]
// Checker: port-level properties of line passing and sleep control
module line_pass_sleep_chk
  import line_pass_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  input wire rx_sample_s  rx_sample,
  input wire logic        link_busy,
  input wire logic        sleep_request_pin,
  input wire logic [8:0]  dout,
  input wire logic        pwm_force_high,
  input wire logic        awake,
  input wire logic        cts_n,
  input wire logic        forward_sample
);
  logic [2:0]  sm_q;   // Shadow of sleep mode select
  logic        cts_q;  // Shadow of CTS enable
  logic [31:0] filt_q; // Shadow of address filter
  // Shadows track bus writes; no peeking inside the design
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sm_q   <= SM_NONE;
      cts_q  <= 1'b1;
      filt_q <= ADDR_FILT_RST;
    end else if (wr_en) begin
      if (addr == OFS_CTRL) begin
        sm_q  <= wdata[2:0];
        cts_q <= wdata[CTRL_CTS_BIT];
      end
      if (addr == OFS_ADDR_FILT) begin
        filt_q <= wdata;
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Pin request held with no link work pending
  sequence pin_sleep_held_s;
    (sm_q == SM_PIN && sleep_request_pin && !link_busy) [*8];
  endsequence
  // Pin request released long enough to wake
  sequence pin_wake_held_s;
    (sm_q == SM_PIN && !sleep_request_pin) [*6];
  endsequence
  AST_RST_STATE: assert property (disable iff (1'b0) !resetn |=> awake && !cts_n && dout == 9'h000)
    else $error("state after reset wrong");
  AST_FILT_READ: assert property (rd_en && addr == OFS_ADDR_FILT |=> rdata == $past(filt_q))
    else $error("filter read back wrong");
  AST_NO_SLEEP: assert property (awake && sm_q == SM_NONE |=> awake)
    else $error("slept with sleep disabled");
  AST_PIN_SLEEP: assert property (pin_sleep_held_s |-> ##[0:4] !awake)
    else $error("pin sleep not entered");
  AST_PIN_WAKE: assert property (pin_wake_held_s |-> awake)
    else $error("pin release did not wake");
  AST_PWM_HIGH: assert property (pwm_force_high == !awake)
    else $error("pwm force differs from sleep");
  AST_CTS_LEVEL: assert property (cts_q |-> cts_n == !awake)
    else $error("cts level differs from sleep");
  AST_FWD_CAUSE: assert property (forward_sample |-> $past(rx_sample.valid))
    else $error("forward without sample");
  AST_NO_FWD_ASLEEP: assert property (!awake |-> !forward_sample)
    else $error("sample forwarded while asleep");
endmodule : line_pass_sleep_chk

bind line_pass_sleep line_pass_sleep_chk line_pass_sleep_chk_i (.*);

// [bench/remote_node_model.sv]
// Partner model: remote sampling node, coordinator and host on the sleep pin
module remote_node_model
  import line_pass_pkg::*;
#(
  parameter int BYTE_CYCLES = 10 // Serial byte time in cycles, kept small
) (
  input  wire logic  ref_clk,
  input  wire logic  cts_n,
  input  wire logic  poll_req,
  output rx_sample_s rx_sample,
  output logic       sleep_request_pin,
  output logic       link_busy,
  output logic       link_activity,
  output logic       poll_data_rx
);
  logic queued; // Coordinator holds data for this node
  // Quiet link, nothing queued, pin low
  initial begin
    rx_sample         = '0;
    sleep_request_pin = 1'b0;
    link_busy         = 1'b0;
    link_activity     = 1'b0;
    poll_data_rx      = 1'b0;
    queued            = 1'b0;
  end
  // Coordinator answers a poll only with queued data
  always @(posedge ref_clk) poll_data_rx <= poll_req && queued;
  // One packet, then inverted fields so stale data never match
  task automatic send(input logic [15:0] s, input logic [31:0] l, input logic [8:0] b);
    @(posedge ref_clk);
    rx_sample     <= '{1'b1, l, s, 9'h1FF, b, 2'b11, 10'h210, 10'h155};
    link_activity <= 1'b1;
    @(posedge ref_clk);
    rx_sample     <= '{1'b0, ~l, ~s, 9'h000, ~b, 2'b00, 10'h1EF, 10'h2AA};
    link_activity <= 1'b0;
  endtask : send
  task automatic set_pin(input logic v);
    @(posedge ref_clk);
    sleep_request_pin <= v;
  endtask : set_pin
  // Link work in progress and coordinator queue
  task automatic set_link(input logic b, input logic q);
    @(posedge ref_clk);
    link_busy <= b;
    queued    <= q;
  endtask : set_link
  // Release, then hold off two byte times after CTS falls
  task automatic host_wake();
    set_pin(1'b0);
    for (int i = 0; i < 400 && cts_n !== 1'b0; i++) @(posedge ref_clk);
    repeat (2 * BYTE_CYCLES) @(posedge ref_clk);
  endtask : host_wake
endmodule : remote_node_model

// [bench/testbench.sv]
// Testbench: registers, line passing, revert and sleep scenarios
module testbench
  import line_pass_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, resetn, wr_en, rd_en;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rd_q;
  rx_sample_s  rx_sample;
  logic        link_busy, link_activity, poll_data_rx, sleep_request_pin;
  logic [8:0]  dout, base_q;   // Outputs and their reference level
  logic [9:0]  pwm_duty0, pwm_duty1;
  logic        pwm_force_high, awake, cts_n, take_sample, forward_sample, poll_req;
  int          mismatches, tests_run, takes, polls;
  line_pass_sleep #(.TENTH_TICKS(10), .MS_TICKS(4)) line_pass_sleep_i (.*);
  remote_node_model remote_node_model_i (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Count sample and poll pulses
  always @(posedge ref_clk) begin
    if (take_sample === 1'b1) takes++;
    if (poll_req === 1'b1) polls++;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    rd_q = rdata;
  endtask : rd
  task automatic wait_awake(input logic v);
    for (int i = 0; i < 400 && awake !== v; i++) @(posedge ref_clk) #1;
    #1;
    chk("awake", {31'h0, v}, {31'h0, awake});
  endtask : wait_awake
  // One awake sample; forward pulse and outputs follow a cycle later
  task automatic push(input logic [15:0] s, input logic [31:0] l, input logic [8:0] b, input logic [8:0] e);
    remote_node_model_i.send(s, l, b);
    #1;
    chk("forward", 32'h1, {31'h0, forward_sample});
    chk("dout", {23'h0, e}, {23'h0, dout});
  endtask : push
  // Lines 0, 3 out low, 2 out high, 1 input; line 0 reverts after two ticks
  task automatic t_lines();
    wr(OFS_SAMPLE, 32'h0);
    wr(OFS_LINE_CFG, 32'h0000095C);
    wr(OFS_DOUT_TMR_L, 32'hFFFFFF01);
    repeat (2) @(posedge ref_clk);
    base_q = dout;
    chk("cfg level", 32'h4, {23'h0, dout & 9'h00D});
    push(16'h1234, 32'h0, 9'h1FA, base_q);
    wr(OFS_ADDR_FILT, 32'h00001234);
    push(16'h1234, 32'h0, 9'h1FA, (base_q & 9'h1F2) | 9'h008);
    push(16'h4321, 32'h0, 9'h005, (base_q & 9'h1F2) | 9'h008);
    wr(OFS_ADDR_FILT, 32'h00ABCDEF);
    push(16'h0000, 32'h00ABCDEF, 9'h005, (base_q & 9'h1F2) | 9'h005);
    wr(OFS_ADDR_FILT, ADDR_ANY);
    push(16'h7777, 32'h1111, 9'h001, (base_q & 9'h1F2) | 9'h001);
    repeat (40) @(posedge ref_clk);
    chk("revert", 32'h0, {23'h0, dout & 9'h00D});
    wr(OFS_DOUT_LVL, 32'h000000FF);
    repeat (60) @(posedge ref_clk);
    chk("override", {23'h0, (base_q & 9'h1F2) | 9'h00D}, {23'h0, dout});
  endtask : t_lines
  // PWM 0 follows channel 0; unconfigured PWM 1 stays
  task automatic t_pwm();
    wr(OFS_PWM_CFG, 32'h00881102);
    wr(OFS_DOUT_TMR_8, 32'h000002FF);
    base_q = dout;
    rd_q   = {22'h0, pwm_duty1};
    push(16'h7777, 32'h0, 9'h00D, base_q);
    chk("duty0", 32'h210, {22'h0, pwm_duty0});
    chk("duty1", rd_q, {22'h0, pwm_duty1});
    repeat (60) @(posedge ref_clk);
    chk("duty0 revert", 32'h011, {22'h0, pwm_duty0});
  endtask : t_pwm
  // Pin sleep, with and without the wake sample
  task automatic t_pin();
    int t;
    logic [31:0] c;
    for (int o = 0; o < 2; o++) begin
      c = CTRL_RST | 32'h1 | (o == 1 ? 32'h20 : 32'h0);
      wr(OFS_CTRL, c);
      rd(OFS_CTRL);
      chk("mode", c, rd_q);
      remote_node_model_i.set_link(1'b1, 1'b0);
      remote_node_model_i.set_pin(1'b1);
      repeat (8) @(posedge ref_clk);
      chk("drain", 32'h1, {31'h0, awake});
      remote_node_model_i.set_link(1'b0, 1'b0);
      wait_awake(1'b0);
      chk("cts asleep", 32'h1, {31'h0, cts_n});
      chk("pwm high", 32'h1, {31'h0, pwm_force_high});
      base_q = dout;
      remote_node_model_i.send(16'h7777, 32'h0, ~dout);
      #1;
      chk("fwd asleep", 32'h0, {31'h0, forward_sample});
      chk("dout asleep", {23'h0, base_q}, {23'h0, dout});
      t = takes;
      remote_node_model_i.host_wake();
      chk("cts awake", 32'h0, {31'h0, cts_n});
      chk("wake sample", (o == 0) ? 32'h1 : 32'h0, {31'h0, takes > t});
    end
  endtask : t_pin
  // Mode 5 with a long period, then mode 4 with a short one
  task automatic t_cyclic();
    int p;
    wr(OFS_SLEEP_TM, 32'hFFFF0010);
    remote_node_model_i.set_pin(1'b1);
    wr(OFS_CTRL, CTRL_RST | 32'h5);
    wait_awake(1'b0);
    remote_node_model_i.set_pin(1'b0);
    wait_awake(1'b1);
    remote_node_model_i.set_pin(1'b1);
    repeat (4) @(posedge ref_clk);
    chk("pin ignored", 32'h1, {31'h0, awake});
    wait_awake(1'b0);
    remote_node_model_i.set_pin(1'b0);
    wait_awake(1'b1);
    wr(OFS_SLEEP_TM, 32'h00030002);
    wr(OFS_CTRL, CTRL_RST | 32'h4);
    wait_awake(1'b0);
    p = polls;
    wait_awake(1'b1);
    wait_awake(1'b0);
    chk("poll", 32'h1, {31'h0, polls > p});
    remote_node_model_i.set_link(1'b0, 1'b1);
    wait_awake(1'b1);
    repeat (4) @(posedge ref_clk);
    chk("poll data", 32'h1, {31'h0, awake});
  endtask : t_cyclic
  task automatic final_report();
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // Run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
  initial begin
    resetn = 1'b0;
    addr   = 8'h00;
    wdata  = 32'h0;
    wr_en  = 1'b0;
    rd_en  = 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(OFS_ADDR_FILT);
    chk("filter reset", ADDR_FILT_RST, rd_q);
    rd(OFS_CTRL);
    chk("ctrl reset", CTRL_RST, rd_q);
    wr(8'hFC, 32'hFFFFFFFF);
    rd(8'hFC);
    chk("unmapped", 32'h0, rd_q);
    t_lines();
    t_pwm();
    t_pin();
    t_cyclic();
    final_report();
  end
endmodule : testbench

// [pkg/line_pass_pkg.sv]
// Package: register map, field codes, timing constants and carrier structs for line passing and sleep control
package line_pass_pkg;

  // Register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFS_CTRL       = 8'h00; // Sleep mode, options, output enables
  localparam logic [7:0] OFS_ADDR_FILT  = 8'h04; // Input address filter
  localparam logic [7:0] OFS_LINE_CFG   = 8'h08; // Line config, 3 bits per line, lines 0..8
  localparam logic [7:0] OFS_PWM_CFG    = 8'h0C; // PWM line config and default duties
  localparam logic [7:0] OFS_DOUT_TMR_L = 8'h10; // Digital output timers lines 0..3
  localparam logic [7:0] OFS_DOUT_TMR_H = 8'h14; // Digital output timers lines 4..7
  localparam logic [7:0] OFS_DOUT_TMR_8 = 8'h18; // Line 8 timer and PWM timeout
  localparam logic [7:0] OFS_SLEEP_TM   = 8'h1C; // Idle timeout and cyclic wake period
  localparam logic [7:0] OFS_SAMPLE     = 8'h20; // Sample interval and samples per packet
  localparam logic [7:0] OFS_DOUT_LVL   = 8'h24; // Digital output level override
  localparam logic [7:0] OFS_STATUS     = 8'h28; // Live state, read only
  localparam logic [7:0] OFS_DUTY       = 8'h2C; // Current PWM duties, read only

  // Field positions inside CTRL
  localparam int CTRL_SM_LSB   = 0;  // Sleep mode select, 3 bits
  localparam int CTRL_SO_LSB   = 4;  // Sleep options, 8 bits
  localparam int CTRL_IU_BIT   = 12; // Sample output enable
  localparam int CTRL_CTS_BIT  = 13; // CTS flow signalling enable
  localparam int SO_NOWAKE_BIT = 1;  // Sleep option: no wake sample

  // Reset values
  localparam logic [31:0] ADDR_FILT_RST = 32'hFFFFFFFF; // Matches no node
  localparam logic [31:0] ADDR_ANY      = 32'h0000FFFF; // Matches any sender
  localparam logic [31:0] CTRL_RST      = 32'h00003000; // Output and CTS enabled, no sleep

  // Encodings
  localparam logic [2:0] LINE_OUT_LOW  = 3'h4;
  localparam logic [2:0] LINE_OUT_HIGH = 3'h5;
  localparam logic [2:0] PWM_CFG_PWM   = 3'h2;
  localparam logic [7:0] TMR_FOREVER   = 8'hFF;
  localparam logic [2:0] SM_NONE       = 3'h0;
  localparam logic [2:0] SM_PIN        = 3'h1;
  localparam logic [2:0] SM_CYCLIC     = 3'h4;
  localparam logic [2:0] SM_CYC_PIN    = 3'h5;

  // Timing
  localparam int CLK_MHZ      = 250;
  localparam int TENTH_S_US   = 100000; // Revert tick, 0.1 s
  localparam int MS_US        = 1000;   // Sample tick, 1 ms
  localparam int TENTH_CYCLES = TENTH_S_US * CLK_MHZ;
  localparam int MS_CYCLES    = MS_US * CLK_MHZ;
  localparam int MIN_SAMPLE_MS = 1;     // No faster than 1 kHz

  // Lines
  localparam int NUM_LINES = 9;
  localparam int NUM_PWM   = 2;

  // Received sample carrier
  typedef struct packed {
    logic        valid;     // One-cycle strobe
    logic [31:0] src_long;  // Sender long address (low word)
    logic [15:0] src_short; // Sender short address
    logic [8:0]  dio_mask;  // Digital lines present
    logic [8:0]  dio_bits;  // Digital levels
    logic [1:0]  adc_mask;  // Channel 0/1 present
    logic [9:0]  adc0;      // Channel 0 value
    logic [9:0]  adc1;      // Channel 1 value
  } rx_sample_s;

  // Sleep state machine
  typedef enum logic [3:0] {
    ST_AWAKE    = 4'b0001,
    ST_DRAIN    = 4'b0010,
    ST_ASLEEP   = 4'b0100,
    ST_POLL     = 4'b1000
  } sleep_state_e;

endpackage : line_pass_pkg

// [rtl/line_pass_sleep.sv]
// Line passing of received samples onto local outputs and sleep control
// Behaviour
// - Sample no faster than once per millisecond
// - Stay awake until samples per packet collected
// - Digital bit n drives only output n
// - Digital update only on output-configured lines
// - Channel 0/1 drives PWM 0/1 if PWM config
// - Update only when sender matches address filter
// - Address filter resets to match nothing
// - Forward samples to serial unless disabled
// - Per-line timer reverts output, 0xFF never
// - Shared PWM timeout reverts duty, 0xFF never
// - Matching sample restarts all revert timers
// - Level override on output lines 0..7, no revert
// - Sample on wake unless option bit set
// - Sleep modes 0, 1, 4, 5
// - Sleep by pin or by idle timeout
// - Finish busy work, then sleep, ignore activity
// - Cyclic wake polls, stays awake if data
// - Wake drives awake high and CTS low
// - Mode 5 pin wake then ignore pin until timeout
// - Activity restarts idle timeout
// - Sleep forces PWM high; line and duty revert timers keep running
// - CTS high asleep, low awake if enabled
// - In mode 5 the pin wakes on its falling edge only
module line_pass_sleep
  import line_pass_pkg::*;
#(
  parameter int TENTH_TICKS = TENTH_CYCLES, // Cycles per 0.1 s tick
  parameter int MS_TICKS    = MS_CYCLES     // Cycles per 1 ms tick
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  input  wire rx_sample_s  rx_sample,
  input  wire logic        link_busy,
  input  wire logic        link_activity,
  input  wire logic        poll_data_rx,
  input  wire logic        sleep_request_pin,
  output logic [8:0]       dout,
  output logic [9:0]       pwm_duty0,
  output logic [9:0]       pwm_duty1,
  output logic             pwm_force_high,
  output logic             awake,
  output logic             cts_n,
  output logic             take_sample,
  output logic             forward_sample,
  output logic             poll_req
);

  // Software registers
  logic [31:0] ctrl_q;         // Mode, options, enables
  logic [31:0] addr_filt_q;    // input_address_filter
  logic [26:0] line_cfg_q;     // line_config per line
  logic [31:0] pwm_cfg_q;      // pwm_line_config and pwm_default_duty
  logic [71:0] dtmr_q;         // digital_output_timer per line
  logic [7:0]  pwm_tmo_q;      // pwm_output_timeout
  logic [31:0] sleep_tm_q;     // idle_timeout [15:0], cyclic_wake_period [31:16] in ms
  logic [31:0] sample_q;       // sample_interval [15:0], samples_per_packet [23:16]

  // Output state
  logic [8:0]  dout_q;
  logic [9:0]  duty_q [NUM_PWM];
  logic [7:0]  dcnt_q [NUM_LINES]; // Digital revert countdown
  logic [8:0]  drun_q;             // Digital revert armed
  logic [7:0]  pcnt_q;             // PWM revert countdown
  logic        prun_q;

  // Sleep state
  sleep_state_e st_q;
  logic [15:0] idle_q;             // Idle countdown in ms
  logic [15:0] wake_q;             // Cyclic wake countdown in ms
  logic [15:0] ivl_q;              // Sample interval countdown
  logic [7:0]  smp_cnt_q;          // Samples collected this wake
  logic        pin_q;              // Previous pin level for edge detect
  logic        pin_wake_q;         // Woke by pin in mode 5
  logic        take_q;
  logic        fwd_q;
  logic        poll_q;
  logic [31:0] rdata_q;

  // Prescalers
  logic [31:0] tenth_cnt_q;
  logic [31:0] ms_cnt_q;
  wire         tenth_tick = (tenth_cnt_q == 32'(TENTH_TICKS - 1));
  wire         ms_tick    = (ms_cnt_q == 32'(MS_TICKS - 1));

  // Field decode
  wire [2:0]   sm        = ctrl_q[CTRL_SM_LSB +: 3];
  wire [7:0]   so        = ctrl_q[CTRL_SO_LSB +: 8];
  wire         iu_en     = ctrl_q[CTRL_IU_BIT];
  wire         cts_en    = ctrl_q[CTRL_CTS_BIT];
  wire [15:0]  idle_tmo  = sleep_tm_q[15:0];
  wire [15:0]  wake_per  = sleep_tm_q[31:16];
  wire [15:0]  smp_ivl   = sample_q[15:0];
  wire [7:0]   smp_pkt   = sample_q[23:16];
  wire         is_pin_md = (sm == SM_PIN) || (sm == SM_CYC_PIN);
  wire         is_cyc_md = (sm == SM_CYCLIC) || (sm == SM_CYC_PIN);
  wire         asleep    = (st_q == ST_ASLEEP);

  // Address match: short, long, or wildcard
  wire addr_hit = (addr_filt_q == ADDR_ANY) ||
                  (addr_filt_q == {16'h0000, rx_sample.src_short}) ||
                  (addr_filt_q == rx_sample.src_long);
  wire rx_ok    = rx_sample.valid && !asleep;         // Radio ignored while asleep
  wire pass_ok  = rx_ok && addr_hit;

  // Register write decodes
  wire wr_lvl   = wr_en && (addr == OFS_DOUT_LVL);
  wire wr_line  = wr_en && (addr == OFS_LINE_CFG);

  // Pin edge decode; pin treated as synchronous
  wire pin_fall = pin_q && !sleep_request_pin;

  // Sample pacing: interval floor of one millisecond
  wire [15:0] ivl_eff = (smp_ivl < 16'(MIN_SAMPLE_MS)) ? 16'(MIN_SAMPLE_MS) : smp_ivl;
  wire        smp_due = (smp_ivl != 16'h0000) && ms_tick && (ivl_q == 16'h0000) && !asleep;
  wire        smp_done = (smp_ivl == 16'h0000) || (smp_cnt_q >= smp_pkt);

  // Idle expiry and sleep entry decisions
  // After a mode 5 pin wake only the idle timeout ends the wake
  wire idle_exp  = is_cyc_md && (idle_q == 16'h0000);
  wire pin_sleep = is_pin_md && sleep_request_pin && !(pin_wake_q && sm == SM_CYC_PIN);
  wire want_sleep = (sm != SM_NONE) && smp_done && (pin_sleep || idle_exp);

  // Prescaler counters
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tenth_cnt_q <= 32'h00000000;
      ms_cnt_q    <= 32'h00000000;
    end else begin
      tenth_cnt_q <= tenth_tick ? 32'h00000000 : tenth_cnt_q + 32'h00000001;
      ms_cnt_q    <= ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
    end
  end

  // Register writes; filter resets to a value no node owns
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_q      <= CTRL_RST;
      addr_filt_q <= ADDR_FILT_RST;
      line_cfg_q  <= 27'h0000000;
      pwm_cfg_q   <= 32'h00000000;
      dtmr_q      <= {9{TMR_FOREVER}};
      pwm_tmo_q   <= TMR_FOREVER;
      sleep_tm_q  <= 32'h00000000;
      sample_q    <= 32'h00000000;
    end else if (wr_en) begin
      case (addr)
        OFS_CTRL:       ctrl_q      <= wdata;
        OFS_ADDR_FILT:  addr_filt_q <= wdata;
        OFS_LINE_CFG:   line_cfg_q  <= wdata[26:0];
        OFS_PWM_CFG:    pwm_cfg_q   <= wdata;
        OFS_DOUT_TMR_L: dtmr_q[31:0]  <= wdata;
        OFS_DOUT_TMR_H: dtmr_q[63:32] <= wdata;
        OFS_DOUT_TMR_8: begin
          dtmr_q[71:64] <= wdata[7:0];
          pwm_tmo_q     <= wdata[15:8];
        end
        OFS_SLEEP_TM:   sleep_tm_q  <= wdata;
        OFS_SAMPLE:     sample_q    <= wdata;
        default:        ;
      endcase
    end
  end

  // Per-line digital output with sample update, override and revert
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      wire [2:0] cfg    = line_cfg_q[3*g +: 3];
      wire       is_out = (cfg == LINE_OUT_LOW) || (cfg == LINE_OUT_HIGH);
      wire       cfg_lv = (cfg == LINE_OUT_HIGH);
      wire [7:0] tmr    = dtmr_q[8*g +: 8];
      wire       upd    = pass_ok && rx_sample.dio_mask[g] && is_out;
      wire       ovr    = wr_lvl && is_out && (g < 8);
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          dout_q[g] <= 1'b0;
          dcnt_q[g] <= 8'h00;
          drun_q[g] <= 1'b0;
        end else if (ovr) begin
          dout_q[g] <= wdata[g];                   // Held until changed
          drun_q[g] <= 1'b0;
        end else if (upd) begin
          dout_q[g] <= rx_sample.dio_bits[g];      // Same-numbered line
          dcnt_q[g] <= tmr;
          drun_q[g] <= (tmr != TMR_FOREVER) && (rx_sample.dio_bits[g] != cfg_lv);
        end else if (pass_ok) begin
          dcnt_q[g] <= tmr;                        // Any matching packet restarts
        end else if (drun_q[g] && tenth_tick) begin
          if (dcnt_q[g] == 8'h00) begin
            dout_q[g] <= cfg_lv;                   // Revert to configured level
            drun_q[g] <= 1'b0;
          end else begin
            dcnt_q[g] <= dcnt_q[g] - 8'h01;
          end
        end else if (wr_line && !drun_q[g]) begin
          dout_q[g] <= (wdata[3*g +: 3] == LINE_OUT_HIGH); // Track new configured level
        end
      end
    end
  endgenerate

  // PWM duty per channel with shared timeout
  generate
    for (g = 0; g < NUM_PWM; g++) begin : g_pwm
      wire [2:0] pcfg = pwm_cfg_q[3*g +: 3];
      wire [9:0] dflt = pwm_cfg_q[8 + 10*g +: 10];
      wire [9:0] val  = (g == 0) ? rx_sample.adc0 : rx_sample.adc1;
      wire       upd  = pass_ok && rx_sample.adc_mask[g] && (pcfg == PWM_CFG_PWM);
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          duty_q[g] <= 10'h000;
        end else if (upd) begin
          duty_q[g] <= val;
        end else if (prun_q && tenth_tick && (pcnt_q == 8'h00)) begin
          duty_q[g] <= dflt;                       // Shared timeout expiry
        end else if (!prun_q && !pass_ok) begin
          duty_q[g] <= dflt;                       // Idle at configured default
        end
      end
    end
  endgenerate

  // Shared PWM timeout counter
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pcnt_q <= 8'h00;
      prun_q <= 1'b0;
    end else if (pass_ok && (rx_sample.adc_mask != 2'b00)) begin
      pcnt_q <= pwm_tmo_q;
      prun_q <= 1'b1;                              // 0xFF never expires below
    end else if (pass_ok) begin
      pcnt_q <= pwm_tmo_q;
    end else if (prun_q && tenth_tick && (pwm_tmo_q != TMR_FOREVER)) begin
      if (pcnt_q == 8'h00) prun_q <= 1'b0;
      else pcnt_q <= pcnt_q - 8'h01;
    end
  end

  // Sleep state machine
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_q       <= ST_AWAKE;
      pin_q      <= 1'b0;
      pin_wake_q <= 1'b0;
      idle_q     <= 16'h0000;
      wake_q     <= 16'h0000;
      take_q     <= 1'b0;
      poll_q     <= 1'b0;
    end else begin
      pin_q  <= sleep_request_pin;
      take_q <= smp_due;
      poll_q <= 1'b0;
      case (st_q)
        ST_AWAKE: begin
          if (link_activity || rx_ok) idle_q <= idle_tmo;
          else if (ms_tick && idle_q != 16'h0000) idle_q <= idle_q - 16'h0001;
          if (sm == SM_NONE) pin_wake_q <= 1'b0;
          else if (want_sleep) st_q <= ST_DRAIN;
        end
        ST_DRAIN: begin
          if (!link_busy) begin
            st_q       <= ST_ASLEEP;
            pin_wake_q <= 1'b0;
            wake_q     <= wake_per;
          end
        end
        ST_ASLEEP: begin
          if (ms_tick && wake_q != 16'h0000) wake_q <= wake_q - 16'h0001;
          if ((sm == SM_PIN) && !sleep_request_pin) begin
            st_q   <= ST_AWAKE;                                        // Level wake
            take_q <= !so[SO_NOWAKE_BIT];
          end else if ((sm == SM_CYC_PIN) && pin_fall) begin
            st_q       <= ST_AWAKE;
            pin_wake_q <= 1'b1;
            idle_q     <= idle_tmo;
            take_q     <= !so[SO_NOWAKE_BIT];
          end else if (is_cyc_md && ms_tick && wake_q <= 16'h0001) begin
            st_q   <= ST_POLL;
            poll_q <= 1'b1;
            take_q <= !so[SO_NOWAKE_BIT];
          end else if (sm == SM_NONE) begin
            st_q <= ST_AWAKE;
          end
        end
        ST_POLL: begin
          if (poll_data_rx) begin
            st_q   <= ST_AWAKE;                                        // Data: stay for timeout
            idle_q <= idle_tmo;
          end else if (!poll_q && !link_busy && smp_done) begin
            st_q   <= ST_ASLEEP;                                       // No answer after poll cycle
            wake_q <= wake_per;
          end
        end
        default: st_q <= ST_AWAKE;
      endcase
    end
  end

  // Samples collected this wake; interval countdown
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      smp_cnt_q <= 8'h00;
      ivl_q     <= 16'h0000;
    end else if (asleep) begin
      smp_cnt_q <= 8'h00;
      ivl_q     <= 16'h0000;
    end else if (ms_tick) begin
      if (ivl_q == 16'h0000) begin
        ivl_q <= ivl_eff - 16'h0001;
        if (smp_ivl != 16'h0000 && smp_cnt_q != 8'hFF) smp_cnt_q <= smp_cnt_q + 8'h01;
      end else begin
        ivl_q <= ivl_q - 16'h0001;
      end
    end
  end

  // Forwarding strobe for the serial side
  always_ff @(posedge ref_clk) begin
    if (!resetn) fwd_q <= 1'b0;
    else fwd_q <= rx_ok && iu_en;
  end

  // Read mux, data valid the cycle after the strobe
  wire [31:0] status_w = {20'h00000, pin_wake_q, prun_q, 6'h00, st_q};
  always_ff @(posedge ref_clk) begin
    if (!resetn) rdata_q <= 32'h00000000;
    else if (rd_en) begin
      case (addr)
        OFS_CTRL:       rdata_q <= ctrl_q;
        OFS_ADDR_FILT:  rdata_q <= addr_filt_q;
        OFS_LINE_CFG:   rdata_q <= {5'h00, line_cfg_q};
        OFS_PWM_CFG:    rdata_q <= pwm_cfg_q;
        OFS_DOUT_TMR_L: rdata_q <= dtmr_q[31:0];
        OFS_DOUT_TMR_H: rdata_q <= dtmr_q[63:32];
        OFS_DOUT_TMR_8: rdata_q <= {16'h0000, pwm_tmo_q, dtmr_q[71:64]};
        OFS_SLEEP_TM:   rdata_q <= sleep_tm_q;
        OFS_SAMPLE:     rdata_q <= sample_q;
        OFS_DOUT_LVL:   rdata_q <= {23'h000000, dout_q};
        OFS_STATUS:     rdata_q <= status_w;
        OFS_DUTY:       rdata_q <= {6'h00, duty_q[1], 6'h00, duty_q[0]};
        default:        rdata_q <= 32'h00000000; // Unmapped reads zero
      endcase
    end else rdata_q <= 32'h00000000;
  end

  // Pin-facing outputs registered; sleep forces PWM high, line revert timers keep running
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      awake          <= 1'b1;
      cts_n          <= 1'b0;
      pwm_force_high <= 1'b0;
    end else begin
      awake          <= !asleep;
      cts_n          <= cts_en ? asleep : 1'b0;
      pwm_force_high <= asleep;
    end
  end

  // Direct flop outputs
  assign dout           = dout_q;                  // No sample updates in sleep, reverts still apply
  assign pwm_duty0      = duty_q[0];
  assign pwm_duty1      = duty_q[1];
  assign take_sample    = take_q;
  assign forward_sample = fwd_q;
  assign poll_req       = poll_q;
  assign rdata          = rdata_q;

endmodule : line_pass_sleep
